//--- include/ffpr_defs.svh
// register offsets, reset values, slot constants and timing counts for the fan ramp block
`ifndef FFPR_DEFS_SVH
`define FFPR_DEFS_SVH
`define FFPR_ADDR_CONFIG1      8'h00
`define FFPR_ADDR_FAN_SPEED    8'h22
`define FFPR_ADDR_FILTER       8'h23
`define FFPR_ADDR_LOCAL_SPAN   8'h24
`define FFPR_ADDR_REMOTE_SPAN  8'h25
`define FFPR_ADDR_LOCAL_TEMP   8'h40
`define FFPR_ADDR_REMOTE_TEMP  8'h41
`define FFPR_ADDR_DUTY_STATUS  8'h42
`define FFPR_RST_CONFIG1       8'h80
`define FFPR_RST_FAN_SPEED     8'h05
`define FFPR_RST_FILTER        8'h10
`define FFPR_RST_LOCAL_SPAN    8'h41
`define FFPR_RST_REMOTE_SPAN   8'h61
`define FFPR_SLOTS             8'hf0
`define FFPR_MIN_DUTY_STEP     8'h10
`define FFPR_CLK_HZ            125000000
`define FFPR_SLOT_HZ           7500
`define FFPR_SLOT_CYCLES       (`FFPR_CLK_HZ / `FFPR_SLOT_HZ)
`define FFPR_UPDATE_SEC_X16    16
`define FFPR_UPDATE_CYCLES_MAX (`FFPR_CLK_HZ * `FFPR_UPDATE_SEC_X16)
`endif

//--- include/ffpr_pkg.sv
// types shared by the fan ramp block
package ffpr_pkg;
    typedef struct packed {
        logic [4:0] startCode;
        logic [2:0] spanCode;
    } ffpr_span_t;
    typedef struct packed {
        logic       spinUpDisable;
        logic [1:0] stepCode;
        logic [2:0] rateCode;
        logic       unused;
        logic       filterEnable;
    } ffpr_filter_t;
    typedef enum logic [2:0] {
        FFPR_IDLE = 3'b001,
        FFPR_CALC = 3'b010,
        FFPR_STEP = 3'b100
    } ffpr_state_t;
endpackage : ffpr_pkg

//--- rtl/ffpr_fan_ramp.sv
// filtered ramp-limited fan pwm with register port
// What this block does
// - remote start temperature in bits 7:3, four degree steps, 0 to 124
// - remote span bits 2:0: 5, 10, 20, 40, 80 degrees
// - filter bit 0 enables ramp filtering, resets to zero
// - each pwm period splits into 240 equal slots
// - one third duty is 80 slots high, 160 low
// - step field bits 6:5 gives 1, 2, 4 or 8 slots
// - filtered: target above held duty raises held duty by step
// - filtered: target below held duty lowers held duty by step
// - adjusted duty is kept as previous value for next compare
// - unfiltered: new duty applied at once after each update
// - rate field bits 4:2 picks sample rate, resets to 100
// - updates per second 0.0625 doubling to 8; one step each
// - filter bit 7 disables spin-up, resets to zero
// - filter bit 1 unused, reads zero
// - minimum duty nibble maps 0..15 linearly to 0..100 percent, reset 5
// - config bit 7 auto mode; bits 6:5 remote-only or fastest
// - local channel has own start and span, same encodings
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ffpr_defs.svh"
module ffpr_fan_ramp #(
    parameter int unsigned UPDATE_BASE = `FFPR_CLK_HZ / 8
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStrobe,
    input  wire logic       rdStrobe,
    output logic      [7:0] rdData,
    // temperature readings, whole degrees
    input  wire logic [7:0] localTemp,
    input  wire logic [7:0] remoteTemp,
    // fan drive
    output logic            pwmOut,
    output logic            spinUpDisable,
    output logic            tempUpdate
);
    logic [7:0]              config1_r;
    logic [7:0]              fanSpeed_r;
    ffpr_pkg::ffpr_filter_t  filter_r;
    ffpr_pkg::ffpr_span_t    localSpan_r;
    ffpr_pkg::ffpr_span_t    remoteSpan_r;
    ffpr_pkg::ffpr_state_t   state_r;
    logic [7:0]              heldDuty_r;
    logic [7:0]              target_r;
    logic [7:0]              activeDuty_r;
    logic [7:0]              slotCnt_r;
    logic [14:0]             slotDiv_r;
    logic [31:0]             updCnt_r;
    logic [7:0]              heldDuty_nxt;
    logic [7:0]              regHit;
    logic                    autoMode;
    logic                    fastestMode;

    // start code in degrees, four per step
    function automatic logic [7:0] startDeg(input ffpr_pkg::ffpr_span_t s);
        return {1'b0, s.startCode, 2'b00};
    endfunction : startDeg

    // span code in degrees
    function automatic logic [7:0] spanDeg(input logic [2:0] c);
        case (c)
            3'h0:    return 8'h05;
            3'h1:    return 8'h0a;
            3'h2:    return 8'h14;
            3'h3:    return 8'h28;
            default: return 8'h50;
        endcase
    endfunction : spanDeg

    // duty in slots for one channel, min duty plus full scale per span above start, capped at full
    function automatic logic [7:0] chanDuty(input ffpr_pkg::ffpr_span_t s,
                                            input logic [7:0] temp,
                                            input logic [3:0] minCode);
        logic [17:0] rise;
        logic [17:0] duty;
        rise = 18'h0;
        duty = 18'h0;
        if (temp < startDeg(s)) begin
            return 8'h00;
        end
        rise = 18'(temp - startDeg(s)) * 18'(`FFPR_SLOTS) / 18'(spanDeg(s.spanCode));
        duty = 18'(minCode) * 18'(`FFPR_MIN_DUTY_STEP) + rise;
        if (duty > 18'(`FFPR_SLOTS)) begin
            return `FFPR_SLOTS;
        end
        return duty[7:0];
    endfunction : chanDuty

    // one-hot register select, shared so reads and writes decode alike
    function automatic logic [7:0] regSel(input logic [7:0] a);
        if (a == `FFPR_ADDR_CONFIG1) begin
            return 8'h01;
        end else if (a == `FFPR_ADDR_FAN_SPEED) begin
            return 8'h02;
        end else if (a == `FFPR_ADDR_FILTER) begin
            return 8'h04;
        end else if (a == `FFPR_ADDR_LOCAL_SPAN) begin
            return 8'h08;
        end else if (a == `FFPR_ADDR_REMOTE_SPAN) begin
            return 8'h10;
        end else if (a == `FFPR_ADDR_LOCAL_TEMP) begin
            return 8'h20;
        end else if (a == `FFPR_ADDR_REMOTE_TEMP) begin
            return 8'h40;
        end else if (a == `FFPR_ADDR_DUTY_STATUS) begin
            return 8'h80;
        end
        return 8'h00;
    endfunction : regSel

    assign regHit      = regSel(addr);
    // mode bits; any code but 11 keeps the loop on the remote channel
    assign autoMode    = config1_r[7];
    assign fastestMode = config1_r[6:5] == 2'b11;

    // register writes; bit 1 of the filter is not stored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config1_r    <= `FFPR_RST_CONFIG1;
            fanSpeed_r   <= `FFPR_RST_FAN_SPEED;
            filter_r     <= `FFPR_RST_FILTER;
            localSpan_r  <= `FFPR_RST_LOCAL_SPAN;
            remoteSpan_r <= `FFPR_RST_REMOTE_SPAN;
        end else if (wrStrobe) begin
            if (regHit[0]) begin
                config1_r <= wrData;
            end else if (regHit[1]) begin
                fanSpeed_r <= {4'h0, wrData[3:0]};
            end else if (regHit[2]) begin
                filter_r <= {wrData[7:2], 1'b0, wrData[0]};
            end else if (regHit[3]) begin
                localSpan_r <= wrData;
            end else if (regHit[4]) begin
                remoteSpan_r <= wrData;
            end
        end
    end

    // read data in the following cycle; unmapped reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            if (regHit[0]) begin
                rdData <= config1_r;
            end else if (regHit[1]) begin
                rdData <= fanSpeed_r;
            end else if (regHit[2]) begin
                rdData <= filter_r;
            end else if (regHit[3]) begin
                rdData <= localSpan_r;
            end else if (regHit[4]) begin
                rdData <= remoteSpan_r;
            end else if (regHit[5]) begin
                rdData <= localTemp;
            end else if (regHit[6]) begin
                rdData <= remoteTemp;
            end else if (regHit[7]) begin
                rdData <= heldDuty_r;
            end else begin
                rdData <= 8'h00;
            end
        end else begin
            rdData <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spinUpDisable <= 1'b0;
        end else begin
            spinUpDisable <= filter_r.spinUpDisable;
        end
    end

    // update period, doubles per slower code
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            updCnt_r   <= 32'h0;
            tempUpdate <= 1'b0;
        end else if (updCnt_r >= (UPDATE_BASE << (3'h7 - filter_r.rateCode)) - 1) begin
            updCnt_r   <= 32'h0;
            tempUpdate <= 1'b1;
        end else begin
            updCnt_r   <= updCnt_r + 32'h1;
            tempUpdate <= 1'b0;
        end
    end

    // step toward target, never past it
    always_comb begin
        logic [8:0] step;
        step = 9'(8'h01 << filter_r.stepCode);
        heldDuty_nxt = heldDuty_r;
        if (target_r > heldDuty_r) begin
            if (9'(heldDuty_r) + step >= 9'(target_r)) begin
                heldDuty_nxt = target_r;
            end else begin
                heldDuty_nxt = heldDuty_r + step[7:0];
            end
        end else if (target_r < heldDuty_r) begin
            if (9'(heldDuty_r) <= 9'(target_r) + step) begin
                heldDuty_nxt = target_r;
            end else begin
                heldDuty_nxt = heldDuty_r - step[7:0];
            end
        end
    end

    // update sequencer; auto mode relies on loop set up first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= ffpr_pkg::FFPR_IDLE;
            target_r   <= 8'h00;
            heldDuty_r <= 8'h00;
        end else begin
            case (state_r)
                ffpr_pkg::FFPR_IDLE: begin
                    if (!autoMode) begin
                        // software mode, nibble to slots
                        // linear duty code
                        heldDuty_r <= 8'(fanSpeed_r[3:0] * `FFPR_MIN_DUTY_STEP);
                    end else if (tempUpdate) begin
                        state_r <= ffpr_pkg::FFPR_CALC;
                    end
                end
                ffpr_pkg::FFPR_CALC: begin
                    // remote only or fastest of both
                    if (fastestMode
                        && chanDuty(localSpan_r, localTemp, fanSpeed_r[3:0])
                           > chanDuty(remoteSpan_r, remoteTemp, fanSpeed_r[3:0])) begin
                        target_r <= chanDuty(localSpan_r, localTemp, fanSpeed_r[3:0]);
                    end else begin
                        target_r <= chanDuty(remoteSpan_r, remoteTemp, fanSpeed_r[3:0]);
                    end
                    state_r <= ffpr_pkg::FFPR_STEP;
                end
                ffpr_pkg::FFPR_STEP: begin
                    if (filter_r.filterEnable) begin
                        heldDuty_r <= heldDuty_nxt;
                    end else begin
                        heldDuty_r <= target_r;
                    end
                    state_r <= ffpr_pkg::FFPR_IDLE;
                end
                default: begin
                    state_r <= ffpr_pkg::FFPR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slotDiv_r <= 15'h0;
            slotCnt_r <= 8'h00;
        end else if (slotDiv_r == 15'(`FFPR_SLOT_CYCLES - 1)) begin
            slotDiv_r <= 15'h0;
            slotCnt_r <= (slotCnt_r == `FFPR_SLOTS - 8'h01) ? 8'h00 : slotCnt_r + 8'h01;
        end else begin
            slotDiv_r <= slotDiv_r + 15'h1;
        end
    end

    // latch duty only at period start, so no runt pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            activeDuty_r <= 8'h00;
        end else if (slotDiv_r == 15'(`FFPR_SLOT_CYCLES - 1)
                     && slotCnt_r == `FFPR_SLOTS - 8'h01) begin
            activeDuty_r <= heldDuty_r;
        end
    end

    // high for duty slots, low rest
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwmOut <= 1'b0;
        end else begin
            pwmOut <= slotCnt_r < activeDuty_r;
        end
    end
endmodule : ffpr_fan_ramp
`default_nettype wire

//--- test/ffpr_fan_model.sv
// fan model: integrates the drive on-time
`timescale 1ns/10ps
`default_nettype none
module ffpr_fan_model (
    // clock, reset and drive from the block
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        pwmOut,
    // on-time seen so far
    output logic      [31:0] onCycles
);
    // unknown drive is not counted as on
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            onCycles <= 32'h0;
        end else if (pwmOut === 1'b1) begin
            onCycles <= onCycles + 32'h1;
        end
    end
endmodule : ffpr_fan_model
`default_nettype wire

//--- test/ffpr_fan_ramp_chk.sv
// port assertions for the filtered fan ramp block
`timescale 1ns/10ps
`default_nettype none
module ffpr_fan_ramp_chk #(
    parameter int unsigned UPDATE_BASE = 50
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic       wrStrobe,
    input wire logic       rdStrobe,
    input wire logic [7:0] rdData,
    // temperatures
    input wire logic [7:0] localTemp,
    input wire logic [7:0] remoteTemp,
    // fan drive
    input wire logic       pwmOut,
    input wire logic       spinUpDisable,
    input wire logic       tempUpdate
);
    logic [31:0] sinceEdge;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // pwm edges may only fall on slot boundaries
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sinceEdge <= 32'h0;
        end else if ($changed(pwmOut)) begin
            sinceEdge <= 32'h0;
        end else begin
            sinceEdge <= sinceEdge + 32'h1;
        end
    end
    a_rd_idle_zero: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
        else $error("read data not zero outside read cycle");
    a_filt_bit_one: assert property ($past(rdStrobe) && $past(addr) == 8'h23 |-> !rdData[1])
        else $error("filter bit 1 reads one");
    a_nibble_only: assert property ($past(rdStrobe) && $past(addr) == 8'h22 |-> rdData[7:4] == 4'h0)
        else $error("speed register upper nibble not zero");
    a_unmapped_rd: assert property ($past(rdStrobe) && $past(addr) == 8'h10 |-> rdData == 8'h00)
        else $error("unmapped read not zero");
    a_duty_range: assert property ($past(rdStrobe) && $past(addr) == 8'h42 |-> rdData <= 8'hf0)
        else $error("held duty above 240 slots");
    a_spin_copy: assert property (wrStrobe && addr == 8'h23 |-> ##2 spinUpDisable == $past(wrData[7], 2))
        else $error("spin-up disable does not follow filter bit 7");
    a_filt_rdback: assert property (wrStrobe && addr == 8'h23 ##2 rdStrobe && addr == 8'h23
        |=> rdData == ($past(wrData, 3) & 8'hfd))
        else $error("filter register readback wrong");
    a_upd_pulse: assert property (tempUpdate |=> !tempUpdate [*8])
        else $error("update pulse too long or too close");
    a_pwm_slot: assert property ($changed(pwmOut) |-> sinceEdge >= 32'd16665)
        else $error("pwm edge off a slot boundary");
endmodule : ffpr_fan_ramp_chk
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the filtered fan ramp block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int unsigned UB = 50;
    logic        ref_clk, rst, wrStrobe, rdStrobe, pwmOut, spinUpDisable, tempUpdate;
    logic [7:0]  addr, wrData, rdData, localTemp, remoteTemp;
    logic [31:0] onCycles;
    int          n_errors, total_checks, cyc, held, seed, k;
    ffpr_fan_ramp #(.UPDATE_BASE(UB)) dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .localTemp(localTemp), .remoteTemp(remoteTemp), .pwmOut(pwmOut),
        .spinUpDisable(spinUpDisable), .tempUpdate(tempUpdate));
    ffpr_fan_model fan (.ref_clk(ref_clk), .rst(rst), .pwmOut(pwmOut), .onCycles(onCycles));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // whole run needs about 41k cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr     <= a;
        wrData   <= d;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr     <= a;
        rdStrobe <= 1'b1;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1 chk({8'h00, rdData}, {8'h00, exp});
    endtask : rdc
    // bounded wait for the next update, k = edges waited
    task automatic pulse(output int n);
        n = 1;
        @(posedge ref_clk);
        #1;
        while (tempUpdate !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask : pulse
    // channel duty: 0 below start, else 80 slots plus m per degree, at most 240
    function automatic int tgt(input int t, input int st, input int m);
        if (t < st) return 0;
        return (80 + (t - st) * m > 240) ? 240 : 80 + (t - st) * m;
    endfunction : tgt
    function automatic int ramp(input int h, input int t, input int s);
        if (t > h) return (h + s > t) ? t : h + s;
        if (t < h) return (h - s < t) ? t : h - s;
        return h;
    endfunction : ramp
    initial begin
        {rst, addr, wrData, wrStrobe, rdStrobe, localTemp, remoteTemp} = {1'b1, 34'h0};
        {n_errors, total_checks, cyc} = '0;
        seed = $urandom(32'h923b6647);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(8'h23, 8'h10);
        rdc(8'h25, 8'h61);
        rdc(8'h22, 8'h05);
        rdc(8'h10, 8'h00);
        // loop set up in software mode before going automatic
        wr(8'h00, 8'h00);
        wr(8'h25, 8'h0b);
        rdc(8'h25, 8'h0b);
        wr(8'h23, 8'h82);
        rdc(8'h23, 8'h80);
        chk({15'h0, spinUpDisable}, 16'h1);
        wr(8'h22, 8'hf3);
        rdc(8'h22, 8'h03);
        rdc(8'h42, 8'h30);
        wr(8'h22, 8'h05);
        wr(8'h00, 8'h80);
        for (int c = 0; c < 8; c++) begin
            wr(8'h23, {3'b000, 3'(c), 2'b00});
            pulse(k);
            pulse(k);
            pulse(k);
            chk(16'(k), 16'(UB << (7 - c)));
        end
        for (int sc = 0; sc < 4; sc++) begin
            remoteTemp <= 8'($urandom_range(50, 0));
            wr(8'h23, 8'h1c);
            pulse(k);
            pulse(k);
            held = tgt(remoteTemp, 4, 6);
            repeat (2) @(posedge ref_clk);
            rdc(8'h42, 8'(held));
            wr(8'h23, {1'b0, 2'(sc), 5'b11101});
            for (int i = 0; i < 8; i++) begin
                pulse(k);
                held = ramp(held, tgt(remoteTemp, 4, 6), 1 << sc);
                repeat (2) @(posedge ref_clk);
                rdc(8'h42, 8'(held));
                remoteTemp <= 8'($urandom_range(50, 0));
                localTemp  <= 8'($urandom);
            end
        end
        // fastest of both channels, local start 32 and span 20, unfiltered
        wr(8'h24, 8'h42);
        rdc(8'h24, 8'h42);
        wr(8'h23, 8'h1c);
        wr(8'h00, 8'he0);
        for (int i = 0; i < 6; i++) begin
            remoteTemp <= 8'($urandom_range(30, 0));
            localTemp  <= 8'($urandom_range(45, 28));
            pulse(k);
            held = tgt(remoteTemp, 4, 6);
            if (tgt(localTemp, 32, 12) > held) held = tgt(localTemp, 32, 12);
            repeat (2) @(posedge ref_clk);
            rdc(8'h42, 8'(held));
        end
        chk(onCycles[15:0], 16'h0);
        end_sim();
    end
endmodule : testbench
bind ffpr_fan_ramp ffpr_fan_ramp_chk #(.UPDATE_BASE(UPDATE_BASE)) chk_i (.ref_clk(ref_clk),
    .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .localTemp(localTemp), .remoteTemp(remoteTemp), .pwmOut(pwmOut),
    .spinUpDisable(spinUpDisable), .tempUpdate(tempUpdate));
`default_nettype wire
